// *** ddc_pkg.sv ***
// package for the receive data path configuration block
// Overview of operation
// [R1] lock bit blocks forward-channel loads
// [R2] forward channel updates low bits unless locked
// [R3] pixel pass outputs pixels ignoring valid strobe
// [R4] pixel pass suppresses packetized audio
// [R5] polarity bit selects valid strobe polarity
// [R6] audio-on-pixel bit zero enables packet output
// [R7] channel B source: register bit or pin
// [R8] width bit: one is 18-bit, zero 24-bit
// [R9] transport bit: one frame, zero data island
// [R10] channel B enable drives blue bit 1
// [R11] checksum enable checks byte after each line
// [R12] checksum mismatch reported in status register
// [R13] reset values 0x00 and 0x10
// [R14] local write beats forward load
package ddc_pkg;
	localparam logic [7:0] DDC_IDX_DATAPATH = 8'h22;
	localparam logic [7:0] DDC_IDX_GENERAL  = 8'h23;
	localparam logic [7:0] DDC_IDX_STATUS   = 8'h24;
	localparam logic [7:0] DDC_RST_DATAPATH = 8'h00;
	localparam logic [7:0] DDC_RST_GENERAL  = 8'h10;
	localparam logic [7:0] DDC_GEN_WMASK    = 8'h80;
	localparam int DDC_B_LOCK   = 7;
	localparam int DDC_B_PASS   = 6;
	localparam int DDC_B_POL    = 5;
	localparam int DDC_B_AUDOFF = 4;
	localparam int DDC_B_CHBSRC = 3;
	localparam int DDC_B_W18    = 2;
	localparam int DDC_B_FRAME  = 1;
	localparam int DDC_B_CHBEN  = 0;
	localparam int DDC_B_CSUM   = 7;
	localparam int DDC_B_CSFAIL = 0;
	localparam logic [1:0] DDC_RESP_OKAY   = 2'b00;
	localparam logic [1:0] DDC_RESP_SLVERR = 2'b10;

	// forward-channel load of the low seven bits
	typedef struct packed {
		logic       valid;
		logic [6:0] bits;
	} ddc_fwd_type;

	// decoded controls toward the data path
	typedef struct packed {
		logic pixel_pass_through;
		logic pixel_valid_polarity;
		logic packet_out_en;
		logic video_18bit;
		logic frame_transport;
		logic chan_b_en;
		logic line_checksum_enable;
	} ddc_ctl_type;
endpackage : ddc_pkg

// *** ddc_regs.sv ***
// configuration registers of the receive data path with an axi4-lite slave
module ddc_regs
	import ddc_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write channels
	input  wire logic [31:0] s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	// axi4-lite read channels
	input  wire logic [31:0] s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	// forward channel load, same clock domain
	input  wire ddc_fwd_type fwd_load,
	// mode-select pin and line checksum events
	input  wire logic        mode_sel_chb_pin,
	input  wire logic        line_end,
	input  wire logic        line_csum_mismatch,
	// pixel valid strobe as received (active high)
	input  wire logic        rx_pixel_valid,
	// data path controls
	output ddc_ctl_type      ctl,
	output logic             pixel_valid_strobe,
	output logic             pixel_out_en,
	output logic             blue_bit1_pin_sel,
	output logic             csum_fail_r
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [1:0] pin_sync_r;
	logic       chb_pin_s;

	// two flops before logic reads the pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_sync_r <= 2'b00;
		end else begin
			pin_sync_r <= {pin_sync_r[0], mode_sel_chb_pin};
		end
	end
	assign chb_pin_s = pin_sync_r[1];

	////////////////////////////////////////////////////////////////////////
	// write channel: accept address and data in either order
	logic        aw_held_r, w_held_r;
	logic [31:0] awaddr_r, wdata_r;
	logic [3:0]  wstrb_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	wire         aw_hs = s_awvalid && s_awready;
	wire         w_hs  = s_wvalid && s_wready;
	wire         aw_ok = aw_held_r || aw_hs;
	wire         w_ok  = w_held_r || w_hs;
	wire         wr_go = aw_ok && w_ok && !bvalid_r;
	wire [31:0]  wr_a  = aw_held_r ? awaddr_r : s_awaddr;
	wire [31:0]  wr_d  = w_held_r ? wdata_r : s_wdata;
	wire [3:0]   wr_s  = w_held_r ? wstrb_r : s_wstrb;
	wire [7:0]   wr_idx = wr_a[9:2];
	wire         wr_dp = wr_go && wr_idx == DDC_IDX_DATAPATH && wr_s[0];
	wire         wr_gp = wr_go && wr_idx == DDC_IDX_GENERAL && wr_s[0];
	wire         wr_hit = wr_idx == DDC_IDX_DATAPATH ||
	                      wr_idx == DDC_IDX_GENERAL ||
	                      wr_idx == DDC_IDX_STATUS;

	assign s_awready = !aw_held_r && !bvalid_r;
	assign s_wready  = !w_held_r && !bvalid_r;
	assign s_bvalid  = bvalid_r;
	assign s_bresp   = bresp_r;

	// hold whichever half came first until the other arrives
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= 32'h0;
			wdata_r   <= 32'h0;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= DDC_RESP_OKAY;
		end else begin
			if (aw_hs) awaddr_r <= s_awaddr;
			if (w_hs) begin
				wdata_r <= s_wdata;
				wstrb_r <= s_wstrb;
			end
			if (wr_go) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_hit ? DDC_RESP_OKAY : DDC_RESP_SLVERR;
			end else begin
				if (aw_hs) aw_held_r <= 1'b1;
				if (w_hs) w_held_r <= 1'b1;
				if (bvalid_r && s_bready) bvalid_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers
	logic [7:0] dp_r, dp_nxt, gp_r;
	wire        fwd_ok = fwd_load.valid && !dp_r[DDC_B_LOCK]; // R1

	// local write first, forward load only when unlocked
	always_comb begin
		dp_nxt = dp_r;
		if (wr_dp) begin
			dp_nxt = wr_d[7:0]; // R14
		end else if (fwd_ok) begin
			dp_nxt = {dp_r[DDC_B_LOCK], fwd_load.bits}; // R2
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dp_r <= DDC_RST_DATAPATH; // R13
			gp_r <= DDC_RST_GENERAL; // R13
		end else begin
			dp_r <= dp_nxt;
			if (wr_gp) gp_r <= (gp_r & ~DDC_GEN_WMASK) |
			                   (wr_d[7:0] & DDC_GEN_WMASK);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checksum failure status, sticky, set wins over clear
	wire csum_ev = gp_r[DDC_B_CSUM] && line_end && line_csum_mismatch; // R11
	wire st_clr  = wr_go && wr_idx == DDC_IDX_STATUS && wr_s[0] &&
	               wr_d[DDC_B_CSFAIL];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			csum_fail_r <= 1'b0;
		end else if (csum_ev) begin
			csum_fail_r <= 1'b1; // R12
		end else if (st_clr) begin
			csum_fail_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read channel, one cycle answer
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;
	wire         ar_hs  = s_arvalid && s_arready;
	wire [7:0]   rd_idx = s_araddr[9:2];
	wire [7:0]   rd_val = rd_idx == DDC_IDX_DATAPATH ? dp_r :
	                      rd_idx == DDC_IDX_GENERAL ? gp_r :
	                      {7'h00, csum_fail_r};
	wire         rd_hit = rd_idx == DDC_IDX_DATAPATH ||
	                      rd_idx == DDC_IDX_GENERAL ||
	                      rd_idx == DDC_IDX_STATUS;

	assign s_arready = !rvalid_r;
	assign s_rvalid  = rvalid_r;
	assign s_rdata   = rdata_r;
	assign s_rresp   = rresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0;
			rresp_r  <= DDC_RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_hit ? {24'h0, rd_val} : 32'h0;
			rresp_r  <= rd_hit ? DDC_RESP_OKAY : DDC_RESP_SLVERR;
		end else if (s_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decoded controls
	wire chb_sel = dp_r[DDC_B_CHBSRC] ? dp_r[DDC_B_CHBEN] : chb_pin_s; // R7
	// pass-through blocks audio packets as well
	wire pkt_en  = !dp_r[DDC_B_AUDOFF] && !dp_r[DDC_B_PASS]; // R4 R6

	// one driver for the whole bundle, members never driven apart
	assign ctl = '{
		pixel_pass_through:   dp_r[DDC_B_PASS],
		pixel_valid_polarity: dp_r[DDC_B_POL],
		packet_out_en:        pkt_en,
		video_18bit:          dp_r[DDC_B_W18], // R8
		frame_transport:      dp_r[DDC_B_FRAME], // R9
		chan_b_en:            chb_sel,
		line_checksum_enable: gp_r[DDC_B_CSUM]
	};

	// strobe polarity and pixel gating
	assign pixel_valid_strobe = rx_pixel_valid ^ dp_r[DDC_B_POL]; // R5
	assign pixel_out_en = rx_pixel_valid || dp_r[DDC_B_PASS]; // R3
	assign blue_bit1_pin_sel = chb_sel; // R10

	////////////////////////////////////////////////////////////////////////
	// checks on the register rules
	AST_LOCK_HOLDS: assert property ( // R1
		@(posedge aclk) disable iff (!aresetn)
		dp_r[DDC_B_LOCK] && !wr_dp |=> $stable(dp_r))
		else $error("locked register changed");
	AST_LOCK_BIT: assert property ( // R1
		@(posedge aclk) disable iff (!aresetn)
		!wr_dp |=> dp_r[DDC_B_LOCK] == $past(dp_r[DDC_B_LOCK]))
		else $error("lock bit moved without a local write");
	AST_FWD_LOAD: assert property ( // R2
		@(posedge aclk) disable iff (!aresetn)
		fwd_load.valid && !dp_r[DDC_B_LOCK] && !wr_dp
		|=> dp_r[6:0] == $past(fwd_load.bits))
		else $error("forward load not taken");
	AST_PASS: assert property ( // R3
		@(posedge aclk) disable iff (!aresetn)
		dp_r[DDC_B_PASS] |-> pixel_out_en)
		else $error("pixels gated while passing");
	AST_NO_AUDIO: assert property ( // R4
		@(posedge aclk) disable iff (!aresetn)
		dp_r[DDC_B_PASS] |-> !ctl.packet_out_en)
		else $error("audio while passing");
	AST_POL: assert property ( // R5
		@(posedge aclk) disable iff (!aresetn)
		dp_r[DDC_B_POL] && rx_pixel_valid |-> !pixel_valid_strobe)
		else $error("strobe polarity wrong");
	AST_AUDOFF: assert property ( // R6
		@(posedge aclk) disable iff (!aresetn)
		dp_r[DDC_B_AUDOFF] |-> !ctl.packet_out_en)
		else $error("audio not suppressed");
	AST_CHB: assert property ( // R7 R10
		@(posedge aclk) disable iff (!aresetn)
		!dp_r[DDC_B_CHBSRC] |-> blue_bit1_pin_sel == pin_sync_r[1])
		else $error("channel b source wrong");
	AST_CSUM: assert property ( // R11 R12
		@(posedge aclk) disable iff (!aresetn)
		csum_ev |=> csum_fail_r)
		else $error("checksum failure lost");
	AST_SET_WINS: assert property ( // R12
		@(posedge aclk) disable iff (!aresetn)
		csum_ev && st_clr |=> csum_fail_r)
		else $error("clear beat a checksum failure");
	AST_CLR: assert property ( // R12
		@(posedge aclk) disable iff (!aresetn)
		st_clr && !csum_ev |=> !csum_fail_r)
		else $error("checksum flag not cleared");
	AST_PRIO: assert property ( // R14
		@(posedge aclk) disable iff (!aresetn)
		wr_dp && fwd_load.valid |=> dp_r == $past(wr_d[7:0]))
		else $error("local write lost");
	AST_RST_VAL: assert property ( // R13
		@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |-> dp_r == DDC_RST_DATAPATH &&
		gp_r == DDC_RST_GENERAL && !csum_fail_r)
		else $error("reset values wrong");
	AST_GP_RO: assert property ( // R13
		@(posedge aclk) disable iff (!aresetn)
		gp_r[6:0] == DDC_RST_GENERAL[6:0])
		else $error("read-only general bits changed");

	// bus answers; readies drop while an answer waits, one of each at a time
	AST_WR_ANSWER: assert property (
		@(posedge aclk) disable iff (!aresetn)
		wr_go |=> s_bvalid)
		else $error("write response missing");
	AST_SLVERR: assert property (
		@(posedge aclk) disable iff (!aresetn)
		wr_go && !wr_hit |=> s_bresp == DDC_RESP_SLVERR)
		else $error("unmapped write not refused");
	AST_ONE_WR: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s_bvalid |-> !s_awready && !s_wready)
		else $error("write taken while response waits");
	AST_RD_ANSWER: assert property (
		@(posedge aclk) disable iff (!aresetn)
		ar_hs |=> s_rvalid && s_rdata[31:8] == 24'h0)
		else $error("read answer missing or wide");
	AST_RD_ONE: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s_rvalid |-> !s_arready)
		else $error("read taken while data waits");
	AST_STRB: assert property (
		@(posedge aclk) disable iff (!aresetn)
		wr_go && !wr_s[0] && !fwd_ok |=> $stable(dp_r) && $stable(gp_r))
		else $error("write without byte strobe landed");

	// coverage of the main scenarios
	COV_FWD: cover property (@(posedge aclk) fwd_ok);
	COV_WRITE: cover property (@(posedge aclk) wr_dp);
	COV_FAIL: cover property (@(posedge aclk) csum_ev);
	COV_READ: cover property (@(posedge aclk) ar_hs);
	COV_PRIO: cover property (@(posedge aclk) wr_dp && fwd_load.valid);

endmodule : ddc_regs

// *** ddc_fwd_model.sv ***
// model of the remote serializer pushing configuration loads
module ddc_fwd_model
	import ddc_pkg::*;
(
	// clock
	input  wire logic aclk,
	// load toward the block
	output ddc_fwd_type fwd_load
);
	timeunit 1ns;
	timeprecision 1ps;
	initial fwd_load = '0;
	// one-cycle pulse; bits inverted after, so stale data never matches
	task send(input logic [6:0] b);
		@(posedge aclk);
		fwd_load <= '{valid: 1'b1, bits: b};
		@(posedge aclk);
		fwd_load <= '{valid: 1'b0, bits: ~b};
	endtask : send
endmodule : ddc_fwd_model

// *** deser_datapath_config_test.sv ***
// self-checking bench of the data path configuration registers
`define CHK(n, e, g) chk(n, (e) !== (g), 32'(e), 32'(g))
module deser_datapath_config_test
	import ddc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] awaddr, wdata, araddr, rd;
	logic [3:0]  wstrb;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        pin, lend, lmis, rxv;
	logic [1:0]  rsp;
	wire         awready, wready, bvalid, arready, rvalid, pvs, poe, b1, cf;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	ddc_ctl_type ctl;
	ddc_fwd_type fwd;
	int          n_errors, n_tests, cyc;

	ddc_fwd_model fwd_m (.aclk(aclk), .fwd_load(fwd));
	ddc_regs dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
		.s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
		.s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
		.s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
		.s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
		.s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
		.s_rready(rready), .fwd_load(fwd), .mode_sel_chb_pin(pin),
		.line_end(lend), .line_csum_mismatch(lmis), .rx_pixel_valid(rxv),
		.ctl(ctl), .pixel_valid_strobe(pvs), .pixel_out_en(poe),
		.blue_bit1_pin_sel(b1), .csum_fail_r(cf));

	////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic bad, input logic [31:0] e, g);
		n_tests++;
		if (bad) begin
			$display("mismatch %s exp %h got %h", n, e, g);
			n_errors++;
		end
	endtask : chk
	task wrap_up;
		if (n_errors == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up
	// each half dropped at its own handshake, bready held until bvalid
	task wr(input logic [31:0] a, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid);
		bready <= 0;
		rsp = bresp;
	endtask : wr
	task rdr(input logic [31:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
		end while (!rvalid);
		rready <= 0;
		rd = rdata;
		rsp = rresp;
	endtask : rdr
	// settle combinational outputs after a register change
	task settle(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask : settle
	task line_ev(input logic m);
		@(posedge aclk);
		lend <= 1;
		lmis <= m;
		@(posedge aclk);
		lend <= 0;
		lmis <= !m;
		@(negedge aclk);
	endtask : line_ev

	////////////////////////////////////////////////////////////////////////
	task t_reset;
		rdr(32'h88);
		`CHK("dp reset", 32'h00, rd);
		rdr(32'h8c);
		`CHK("gp reset", 32'h10, rd);
		`CHK("gp resp", DDC_RESP_OKAY, rsp);
		rdr(32'h90);
		`CHK("status reset", 32'h0, rd);
		`CHK("flag reset", 1'b0, cf);
		rdr(32'h40);
		`CHK("unmapped resp", DDC_RESP_SLVERR, rsp);
		`CHK("unmapped data", 32'h0, rd);
		wr(32'h40, 8'h01);
		`CHK("unmapped wresp", DDC_RESP_SLVERR, rsp);
	endtask : t_reset
	// forward loads land unless the lock bit is set or a local write lands on the same edge
	task t_fwd;
		fwd_m.send(7'h55);
		rdr(32'h88);
		`CHK("fwd load", 32'h55, rd);
		// local write and forward load land on the same edge
		fork
			wr(32'h88, 8'h0a);
			fwd_m.send(7'h33);
		join
		rdr(32'h88);
		`CHK("local wins", 32'h0a, rd);
		wstrb <= 4'he;
		wr(32'h88, 8'h33);
		wstrb <= 4'hf;
		`CHK("no strobe resp", DDC_RESP_OKAY, rsp);
		rdr(32'h88);
		`CHK("no strobe", 32'h0a, rd);
		wr(32'h88, 8'h80);
		`CHK("wr resp", DDC_RESP_OKAY, rsp);
		fwd_m.send(7'h2a);
		rdr(32'h88);
		`CHK("locked", 32'h80, rd);
	endtask : t_fwd
	task t_bits;
		wr(32'h88, 8'h60);
		settle(0);
		`CHK("pass oe", 1'b1, poe);
		`CHK("pass audio", 1'b0, ctl.packet_out_en);
		`CHK("pol inv", 1'b1, pvs);
		`CHK("pass flag", 1'b1, ctl.pixel_pass_through);
		`CHK("pol flag", 1'b1, ctl.pixel_valid_polarity);
		wr(32'h88, 8'h17);
		settle(0);
		`CHK("audio off", 1'b0, ctl.packet_out_en);
		`CHK("w18", 1'b1, ctl.video_18bit);
		`CHK("frame", 1'b1, ctl.frame_transport);
		`CHK("chb pin src", 1'b0, b1);
		`CHK("chb pin ctl", 1'b0, ctl.chan_b_en);
		wr(32'h88, 8'h09);
		settle(0);
		`CHK("chb reg", 1'b1, b1);
		`CHK("chb reg ctl", 1'b1, ctl.chan_b_en);
		`CHK("audio on", 1'b1, ctl.packet_out_en);
		`CHK("w24", 1'b0, ctl.video_18bit);
		`CHK("island", 1'b0, ctl.frame_transport);
		`CHK("pol pos", 1'b0, pvs);
		`CHK("no pass", 1'b0, poe);
		@(posedge aclk);
		rxv <= 1;
		settle(0);
		`CHK("pol pos act", 1'b1, pvs);
		`CHK("valid oe", 1'b1, poe);
		wr(32'h88, 8'h20);
		settle(0);
		`CHK("pol inv act", 1'b0, pvs);
		wr(32'h88, 8'h08);
		rxv <= 0;
		settle(0);
		`CHK("chb reg off", 1'b0, b1);
		wr(32'h88, 8'h00);
		pin <= 1;
		settle(4);
		`CHK("chb pin on", 1'b1, b1);
		`CHK("chb pin ctl on", 1'b1, ctl.chan_b_en);
	endtask : t_bits
	task t_csum;
		line_ev(1);
		`CHK("csum off", 1'b0, cf);
		wr(32'h8c, 8'h7f);
		rdr(32'h8c);
		`CHK("gp ro bits", 32'h10, rd);
		`CHK("csum en off", 1'b0, ctl.line_checksum_enable);
		wr(32'h8c, 8'h80);
		rdr(32'h8c);
		`CHK("gp en", 32'h90, rd);
		`CHK("csum en on", 1'b1, ctl.line_checksum_enable);
		line_ev(0);
		`CHK("csum good", 1'b0, cf);
		line_ev(1);
		`CHK("csum bad", 1'b1, cf);
		rdr(32'h90);
		`CHK("status set", 32'h1, rd);
		wr(32'h90, 8'h01);
		rdr(32'h90);
		`CHK("status clr", 32'h0, rd);
		// failure and clear on the same edge: the failure stays
		fork
			wr(32'h90, 8'h01);
			line_ev(1);
		join
		rdr(32'h90);
		`CHK("set wins", 32'h1, rd);
	endtask : t_csum
	// a second reset in mid-run brings back every reset value
	task t_rerun;
		wr(32'h88, 8'h7f);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		rdr(32'h88);
		`CHK("dp re-reset", 32'h00, rd);
		rdr(32'h8c);
		`CHK("gp re-reset", 32'h10, rd);
		rdr(32'h90);
		`CHK("status re-reset", 32'h0, rd);
		`CHK("flag re-reset", 1'b0, cf);
	endtask : t_rerun

	////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end
	// hang guard, far above the fewer than two hundred cycles the run needs
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up;
		end
	end
	initial begin
		{awaddr, wdata, araddr, awvalid, wvalid, bready} = '0;
		{arvalid, rready, pin, lend, lmis, rxv, aresetn} = '0;
		wstrb = 4'hf;
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		t_reset;
		t_fwd;
		t_bits;
		t_csum;
		t_rerun;
		wrap_up;
	end
endmodule : deser_datapath_config_test
